// [hw/cef_map.vh]
// Constants for the embedded FIFO: register offsets, field positions,
// reset values and storage size. Assumes 32-bit APB, word-aligned.
`ifndef CEF_MAP_VH
`define CEF_MAP_VH

// ==========================================================
// Storage
`define CEF_MEM_BITS 16384
`define CEF_MEM_WORDS 512
`define CEF_PTR_W 14
`define CEF_CNT_W 15

// ==========================================================
// Register offsets (byte addresses)
`define CEF_REG_CTRL 12'h000
`define CEF_REG_FULL_THR 12'h004
`define CEF_REG_AFULL_THR 12'h008
`define CEF_REG_AEMPTY_THR 12'h00c
`define CEF_REG_STATUS 12'h010
`define CEF_REG_CMD 12'h014

// ==========================================================
// Control register fields
`define CEF_CTRL_WIDTH_LSB 0
`define CEF_CTRL_SHOW_AHEAD 3
`define CEF_CTRL_WCLK_LSB 4
`define CEF_CTRL_WCLK_INV 7
`define CEF_CTRL_WCE_LSB 8
`define CEF_CTRL_WCE_INV 10
`define CEF_CTRL_RCLK_LSB 11
`define CEF_CTRL_RCLK_INV 14
`define CEF_CTRL_RCE_LSB 15
`define CEF_CTRL_RCE_INV 17
`define CEF_CTRL_LRST_INV 18
`define CEF_CTRL_BITS 19
`define CEF_CTRL_RESET 19'h00005

// ==========================================================
// Status register fields
`define CEF_ST_FULL 0
`define CEF_ST_AFULL 1
`define CEF_ST_EMPTY 2
`define CEF_ST_AEMPTY 3
`define CEF_ST_CNT_LSB 16

// ==========================================================
// Command register fields
`define CEF_CMD_REWIND 0

// ==========================================================
// Threshold reset values
`define CEF_FULL_THR_RESET 15'h4000
`define CEF_AFULL_THR_RESET 15'h3c00
`define CEF_AEMPTY_THR_RESET 15'h0400

`endif

// [hw/cef_skid.v]
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on clk_sys; data storage is not reset.
`timescale 1ns/1ns
module cef_skid #(
  parameter DW = 32
) (
  input wire clk_sys,
  input wire resetn,
  input wire clear,
  input wire in_valid,
  output wire in_ready,
  input wire [DW-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [DW-1:0] out_data
);
  reg [DW-1:0] ent_reg [0:1];
  reg [1:0] cnt_reg;
  reg wr_idx_reg;
  reg rd_idx_reg;
  wire take;
  wire give;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = ent_reg[rd_idx_reg];
  assign take = in_valid && in_ready;
  assign give = out_valid && out_ready;

  // ==========================================================
  // Entries: no reset, like the read data register
  always @(posedge clk_sys) begin
    if (take) begin
      ent_reg[wr_idx_reg] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn || clear) begin
      cnt_reg <= 2'h0;
      wr_idx_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
    end else begin
      if (take) begin
        wr_idx_reg <= ~wr_idx_reg;
      end
      if (give) begin
        rd_idx_reg <= ~rd_idx_reg;
      end
      if (take && !give) begin
        cnt_reg <= cnt_reg + 2'h1;
      end else if (give && !take) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
endmodule

// [hw/cef_fifo.v]
// Embedded FIFO with programmable flags, rewind and show-ahead read.
// Assumes fabric logic on clk_sys drives push/pop ports; global
// clock nets arrive asynchronously and are resynchronised here.
// Operation
// - Four flags are driven: full, empty, almost full, almost empty.
// - Full, almost-full and almost-empty thresholds are programmable.
// - User logic may reset the read pointer to replay a frame.
// - Read data is registered, or shows the next entry in show-ahead.
// - Storage totals 16,384 bits with one port per side.
// - Word width is 1, 2, 4, 8, 16 or 32 bits; depth scales inversely.
// - Data, enables and flags are sampled or updated on clock edges.
// - Write data, full and almost full share write clock and enable.
// - Read data (except in show-ahead), empty and almost empty share read clock and enable.
// - Read and write sides may run from common or separate clocks.
// - Write clock is the dedicated clock or global net 0-3; only a net selection is invertible.
// - Write enable source is the write enable or net 1-2, invertible.
// - Read clock and read enable are selected the same way.
// - Flags clear on global reset OR invertible local reset.
// - One reset applies to all FIFO signals together.
`timescale 1ns/1ns
`include "cef_map.vh"
module cef_fifo #(
  parameter AW = 12
) (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [3:0] global_clock_nets,
  input wire local_reset,
  input wire push_valid,
  output wire push_ready,
  input wire [31:0] push_data,
  input wire pop_enable,
  output reg [31:0] pop_data,
  output reg pop_valid,
  input wire rewind_req,
  output reg full,
  output reg almost_full,
  output reg empty,
  output reg almost_empty
);
  // ==========================================================
  // Configuration registers
  reg [`CEF_CTRL_BITS-1:0] ctrl_reg;
  reg [`CEF_CNT_W-1:0] full_thr_reg;
  reg [`CEF_CNT_W-1:0] afull_thr_reg;
  reg [`CEF_CNT_W-1:0] aempty_thr_reg;
  wire [2:0] width_code;
  wire [2:0] lw;
  wire show_ahead;
  wire [2:0] wclk_sel;
  wire [1:0] wce_sel;
  wire [2:0] rclk_sel;
  wire [1:0] rce_sel;
  wire apb_setup;
  wire apb_wr;
  reg rewind_cmd;

  assign width_code = ctrl_reg[`CEF_CTRL_WIDTH_LSB+2:`CEF_CTRL_WIDTH_LSB];
  // Codes above 5 fall back to 32 bits
  assign lw = (width_code > 3'h5) ? 3'h5 : width_code;
  assign show_ahead = ctrl_reg[`CEF_CTRL_SHOW_AHEAD];
  assign wclk_sel = ctrl_reg[`CEF_CTRL_WCLK_LSB+2:`CEF_CTRL_WCLK_LSB];
  assign wce_sel = ctrl_reg[`CEF_CTRL_WCE_LSB+1:`CEF_CTRL_WCE_LSB];
  assign rclk_sel = ctrl_reg[`CEF_CTRL_RCLK_LSB+2:`CEF_CTRL_RCLK_LSB];
  assign rce_sel = ctrl_reg[`CEF_CTRL_RCE_LSB+1:`CEF_CTRL_RCE_LSB];

  // ==========================================================
  // Reset: global OR local, one reset for all FIFO state
  wire clr;
  assign clr = !resetn ||
    (local_reset ^ ctrl_reg[`CEF_CTRL_LRST_INV]);

  // ==========================================================
  // Global clock nets: three flops, change taken when 2nd and 3rd agree
  reg [3:0] gn_s1_reg;
  reg [3:0] gn_s2_reg;
  reg [3:0] gn_s3_reg;
  reg [3:0] gn_lvl_reg;
  reg [3:0] gn_lvl_d_reg;
  wire [3:0] gn_rise;
  wire [3:0] gn_fall;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      gn_s1_reg <= 4'h0;
      gn_s2_reg <= 4'h0;
      gn_s3_reg <= 4'h0;
      gn_lvl_d_reg <= 4'h0;
    end else begin
      gn_s1_reg <= global_clock_nets;
      gn_s2_reg <= gn_s1_reg;
      gn_s3_reg <= gn_s2_reg;
      gn_lvl_d_reg <= gn_lvl_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_net
      always @(posedge clk_sys) begin
        if (!resetn) begin
          gn_lvl_reg[gi] <= 1'b0;
        end else if (gn_s2_reg[gi] == gn_s3_reg[gi]) begin
          gn_lvl_reg[gi] <= gn_s3_reg[gi];
        end
      end
    end
  endgenerate

  assign gn_rise = gn_lvl_reg & ~gn_lvl_d_reg;
  assign gn_fall = ~gn_lvl_reg & gn_lvl_d_reg;

  // Clock source: 0 dedicated (every clk_sys edge), 1-4 net 0-3.
  // Inversion picks the falling edge of a net; no effect on 0.
  function step_sel;
    input [2:0] sel;
    input inv;
    input [3:0] rise;
    input [3:0] fall;
    begin
      case (sel)
        3'h0: step_sel = 1'b1;
        3'h1: step_sel = inv ? fall[0] : rise[0];
        3'h2: step_sel = inv ? fall[1] : rise[1];
        3'h3: step_sel = inv ? fall[2] : rise[2];
        3'h4: step_sel = inv ? fall[3] : rise[3];
        default: step_sel = 1'b0;
      endcase
    end
  endfunction

  // Enable source: 0 the side's own enable, 1-2 net level 1-2
  function ce_sel;
    input [1:0] sel;
    input inv;
    input en;
    input [3:0] lvl;
    begin
      case (sel)
        2'h1: ce_sel = lvl[1] ^ inv;
        2'h2: ce_sel = lvl[2] ^ inv;
        default: ce_sel = en ^ inv;
      endcase
    end
  endfunction

  // ==========================================================
  // Input buffer: a stalled write side back-pressures push_ready
  wire buf_valid;
  wire buf_ready;
  wire [31:0] buf_data;

  cef_skid #(
    .DW(32)
  ) u_skid (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(clr),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // ==========================================================
  // Pointers, occupancy and storage
  reg [31:0] mem [0:`CEF_MEM_WORDS-1];
  reg [`CEF_PTR_W-1:0] wptr_reg;
  reg [`CEF_PTR_W-1:0] rptr_reg;
  reg [`CEF_CNT_W-1:0] cnt_reg;
  wire [`CEF_CNT_W-1:0] depth;
  wire [`CEF_CNT_W-1:0] cap;
  wire [`CEF_PTR_W-1:0] last;
  wire w_step;
  wire w_ce;
  wire r_step;
  wire r_ce;
  wire do_wr;
  wire do_rd;
  wire do_rew;
  wire [`CEF_PTR_W-1:0] wptr_inc;
  wire [`CEF_PTR_W-1:0] rptr_inc;

  // Depth scales inversely with width
  assign depth = 15'h4000 >> lw;
  assign last = depth[`CEF_PTR_W-1:0] - 14'h1;
  assign cap = (full_thr_reg > depth) ? depth : full_thr_reg;

  assign w_step = step_sel(wclk_sel, ctrl_reg[`CEF_CTRL_WCLK_INV],
    gn_rise, gn_fall);
  assign w_ce = ce_sel(wce_sel, ctrl_reg[`CEF_CTRL_WCE_INV],
    buf_valid, gn_lvl_reg);
  assign r_step = step_sel(rclk_sel, ctrl_reg[`CEF_CTRL_RCLK_INV],
    gn_rise, gn_fall);
  assign r_ce = ce_sel(rce_sel, ctrl_reg[`CEF_CTRL_RCE_INV],
    pop_enable, gn_lvl_reg);

  // Protection uses live occupancy, not the registered flags
  assign do_wr = w_step && w_ce && buf_valid && (cnt_reg < cap);
  assign buf_ready = do_wr;
  assign do_rew = rewind_req || rewind_cmd;
  assign do_rd = r_step && r_ce && (cnt_reg != 15'h0) && !do_rew;

  assign wptr_inc = (wptr_reg >= last) ? 14'h0 : wptr_reg + 14'h1;
  assign rptr_inc = (rptr_reg >= last) ? 14'h0 : rptr_reg + 14'h1;

  // Bit address of an entry, split into word and bit offset
  wire [`CEF_PTR_W-1:0] wbit;
  wire [`CEF_PTR_W-1:0] rbit;
  wire [`CEF_PTR_W-1:0] rbit_inc;
  wire [31:0] lane;
  wire [31:0] wmask;

  assign wbit = wptr_reg << lw;
  assign rbit = rptr_reg << lw;
  assign rbit_inc = rptr_inc << lw;
  assign lane = (lw == 3'h5) ? 32'hffffffff :
    ((32'h1 << (6'h1 << lw)) - 32'h1);
  assign wmask = lane << wbit[4:0];

  // Word storage: no reset, partial-word write merges lanes
  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wbit[13:5]] <= (mem[wbit[13:5]] & ~wmask) |
        ((buf_data & lane) << wbit[4:0]);
    end
  end

  wire [31:0] rd_head;
  wire [31:0] rd_next;
  assign rd_head = (mem[rbit[13:5]] >> rbit[4:0]) & lane;
  assign rd_next = (mem[rbit_inc[13:5]] >> rbit_inc[4:0]) & lane;

  always @(posedge clk_sys) begin
    if (clr) begin
      wptr_reg <= 14'h0;
      rptr_reg <= 14'h0;
      cnt_reg <= 15'h0;
    end else begin
      if (do_wr) begin
        wptr_reg <= wptr_inc;
      end
      if (do_rew) begin
        // Replay from storage start; valid until write side wraps
        rptr_reg <= 14'h0;
        cnt_reg <= do_wr ? {1'b0, wptr_inc} : {1'b0, wptr_reg};
      end else begin
        if (do_rd) begin
          rptr_reg <= rptr_inc;
        end
        if (do_wr && !do_rd) begin
          cnt_reg <= cnt_reg + 15'h1;
        end else if (do_rd && !do_wr) begin
          cnt_reg <= cnt_reg - 15'h1;
        end
      end
    end
  end

  // ==========================================================
  // Read port: registered, or show-ahead of the head entry
  always @(posedge clk_sys) begin
    if (clr) begin
      pop_valid <= 1'b0;
    end else if (show_ahead) begin
      pop_valid <= do_rew ? 1'b0 : ((cnt_reg - (do_rd ? 15'h1 : 15'h0) +
        (do_wr ? 15'h1 : 15'h0)) != 15'h0);
    end else begin
      pop_valid <= do_rd;
    end
  end

  // Data register not reset; show-ahead follows the new head
  always @(posedge clk_sys) begin
    if (show_ahead) begin
      pop_data <= do_rd ? rd_next : rd_head;
    end else if (do_rd) begin
      pop_data <= rd_head;
    end
  end

  // ==========================================================
  // Flags: write pair on write clock/enable, read pair on read side
  always @(posedge clk_sys) begin
    if (clr) begin
      full <= 1'b0;
      almost_full <= 1'b0;
    end else if (w_step && w_ce) begin
      full <= (cnt_reg >= cap);
      almost_full <= (cnt_reg >= afull_thr_reg);
    end
  end

  always @(posedge clk_sys) begin
    if (clr) begin
      empty <= 1'b0;
      almost_empty <= 1'b0;
    end else if (r_step && r_ce) begin
      empty <= (cnt_reg == 15'h0);
      almost_empty <= (cnt_reg <= aempty_thr_reg);
    end
  end

  // ==========================================================
  // APB slave: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= `CEF_CTRL_RESET;
      full_thr_reg <= `CEF_FULL_THR_RESET;
      afull_thr_reg <= `CEF_AFULL_THR_RESET;
      aempty_thr_reg <= `CEF_AEMPTY_THR_RESET;
      rewind_cmd <= 1'b0;
    end else begin
      rewind_cmd <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `CEF_REG_CTRL: ctrl_reg <= pwdata[`CEF_CTRL_BITS-1:0];
          `CEF_REG_FULL_THR: full_thr_reg <= pwdata[14:0];
          `CEF_REG_AFULL_THR: afull_thr_reg <= pwdata[14:0];
          `CEF_REG_AEMPTY_THR: aempty_thr_reg <= pwdata[14:0];
          `CEF_REG_CMD: rewind_cmd <= pwdata[`CEF_CMD_REWIND];
          default: rewind_cmd <= 1'b0;
        endcase
      end
    end
  end

  // Read data captured in setup so it is a flop during access
  always @(posedge clk_sys) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      case (paddr)
        `CEF_REG_CTRL: prdata <= {13'h0, ctrl_reg};
        `CEF_REG_FULL_THR: prdata <= {17'h0, full_thr_reg};
        `CEF_REG_AFULL_THR: prdata <= {17'h0, afull_thr_reg};
        `CEF_REG_AEMPTY_THR: prdata <= {17'h0, aempty_thr_reg};
        `CEF_REG_STATUS: prdata <= {1'b0, cnt_reg, 12'h0, almost_empty,
          empty, almost_full, full};
        `CEF_REG_CMD: prdata <= 32'h0;
        default: begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      // Error stands only for the access cycle
      pslverr <= 1'b0;
    end
  end
endmodule

// [verif/cef_fifo_properties.sv]
// Port-level checker for the embedded FIFO.
// Assumes default read-enable source and active-high local reset.
`timescale 1ns/1ns
module cef_fifo_properties #(
  parameter AW = 12
) (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire [AW-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire local_reset,
  input wire pop_enable,
  input wire push_ready,
  input wire pop_valid,
  input wire full,
  input wire almost_full,
  input wire empty,
  input wire almost_empty
);
  // ====================
  // Sequences
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_bad;
    s_acc ##0 (paddr > 12'h014);
  endsequence
  // Read flags move only after a read-enable edge or a local reset
  sequence s_rd_cause;
    $past(pop_enable) || $past(local_reset);
  endsequence
  // ====================
  // Properties
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR_PHASE: assert property (pslverr |-> s_acc)
    else $error("pslverr outside access");
  AST_UNMAPPED_ERR: assert property (s_bad |-> pslverr)
    else $error("no error on unmapped");
  AST_UNMAPPED_DATA: assert property (s_bad |-> prdata == 32'h0)
    else $error("data on unmapped");
  AST_FULL_EMPTY: assert property (!(full && empty))
    else $error("full and empty");
  AST_EMPTY_CAUSE: assert property (!$stable(empty) |-> s_rd_cause)
    else $error("empty moved without enable");
  AST_AEMPTY_CAUSE: assert property (
    !$stable(almost_empty) |-> s_rd_cause)
    else $error("almost empty moved");
  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) !resetn |=>
    !full && !almost_full && !empty && !almost_empty && !pop_valid &&
    push_ready && !pslverr)
    else $error("state after reset");
endmodule

bind cef_fifo cef_fifo_properties #(.AW(AW)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .local_reset(local_reset), .pop_enable(pop_enable),
  .push_ready(push_ready), .pop_valid(pop_valid), .full(full),
  .almost_full(almost_full), .empty(empty), .almost_empty(almost_empty));

// [verif/cef_user.sv]
// Fabric-side source of push words.
// Assumes clk_sys; go is a one-cycle start pulse.
`timescale 1ns/1ns
module cef_user (
  input wire clk_sys,
  input wire resetn,
  input wire go,
  input wire [7:0] n_words,
  input wire [31:0] base,
  input wire push_ready,
  output logic push_valid,
  output logic [31:0] push_data,
  output logic [7:0] sent
);
  // Held until taken; released data is inverted so it never looks valid
  always @(posedge clk_sys) begin
    if (!resetn) begin
      push_valid <= 1'b0;
      push_data <= 32'h0;
      sent <= 8'h0;
    end else if (go) begin
      sent <= 8'h0;
      push_valid <= (n_words != 8'h0);
      push_data <= base;
    end else if (push_valid && push_ready) begin
      sent <= sent + 8'h1;
      push_valid <= (sent + 8'h1 < n_words);
      push_data <= (sent + 8'h1 < n_words) ? push_data + 32'h1 : ~push_data;
    end
  end
endmodule

// [verif/cef_fifo_tb.sv]
// Self-checking bench for the embedded FIFO.
// Assumes one clock; global clock nets are driven only by t_nets.
`timescale 1ns/1ns
`include "cef_map.vh"
module cef_fifo_tb;
  logic clk_sys, resetn, psel, penable, pwrite, local_reset, err, go;
  logic pready, pslverr, push_valid, push_ready, pop_enable, pop_valid;
  logic rewind_req, full, almost_full, empty, almost_empty;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, push_data, pop_data, rd, base;
  logic [7:0] n_words, sent;
  logic [3:0] gnets;
  int num_errors, comparisons, cyc;

  cef_fifo dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_clock_nets(gnets), .local_reset(local_reset),
    .push_valid(push_valid), .push_ready(push_ready),
    .push_data(push_data), .pop_enable(pop_enable), .pop_data(pop_data),
    .pop_valid(pop_valid), .rewind_req(rewind_req), .full(full),
    .almost_full(almost_full), .empty(empty), .almost_empty(almost_empty));
  cef_user u_user (.clk_sys(clk_sys), .resetn(resetn), .go(go),
    .n_words(n_words), .base(base), .push_ready(push_ready),
    .push_valid(push_valid), .push_data(push_data), .sent(sent));

  // ====================
  // Helpers
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic push(input logic [7:0] n, input logic [31:0] b);
    n_words <= n;
    base <= b;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 60 && sent !== n; i++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic pop(input logic [31:0] exp, input logic hit);
    logic got;
    got = 1'b0;
    pop_enable <= 1'b1;
    @(posedge clk_sys);
    pop_enable <= 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      if (pop_valid === 1'b1 && !got) begin
        got = 1'b1;
        chk(pop_data, exp);
      end
    end
    chk({31'h0, got}, {31'h0, hit});
  endtask
  task automatic lrst;
    local_reset <= 1'b1;
    @(posedge clk_sys);
    local_reset <= 1'b0;
    @(posedge clk_sys);
  endtask

  // ====================
  // Scenarios
  task automatic t_regs;
    rchk(`CEF_REG_CTRL, 32'h00000005);
    rchk(`CEF_REG_FULL_THR, 32'h00004000);
    rchk(`CEF_REG_AFULL_THR, 32'h00003c00);
    rchk(`CEF_REG_AEMPTY_THR, 32'h00000400);
    rchk(`CEF_REG_STATUS, 32'h00000000);
    rchk(12'h018, 32'h00000000);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `CEF_REG_FULL_THR, 32'h8);
    apb(1'b1, `CEF_REG_AFULL_THR, 32'h6);
    apb(1'b1, `CEF_REG_AEMPTY_THR, 32'h2);
    rchk(`CEF_REG_FULL_THR, 32'h00000008);
  endtask
  // Two words wait in the buffer while the memory is full
  task automatic t_fill;
    push(8'd10, 32'ha0);
    chk({29'h0, full, almost_full, push_ready}, 32'h6);
    rchk(`CEF_REG_STATUS, 32'h00080003);
    for (int i = 0; i < 10; i++) begin
      pop(32'ha0 + i, 1'b1);
      if (i == 5) chk({31'h0, almost_empty}, 32'h0);
    end
    pop(32'h0, 1'b0);
    chk({30'h0, empty, almost_empty}, 32'h3);
  endtask
  task automatic t_rewind;
    lrst;
    chk({28'h0, full, almost_full, empty, almost_empty}, 32'h0);
    push(8'd3, 32'hb0);
    pop(32'hb0, 1'b1);
    pop(32'hb1, 1'b1);
    rewind_req <= 1'b1;
    @(posedge clk_sys);
    rewind_req <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) pop(32'hb0 + i, 1'b1);
    pop(32'h0, 1'b0);
    apb(1'b1, `CEF_REG_CMD, 32'h1);
    pop(32'hb0, 1'b1);
  endtask
  // Write side stepped by net 0 rising edge only
  task automatic t_nets;
    lrst;
    apb(1'b1, `CEF_REG_CTRL, 32'h00000015);
    push(8'd1, 32'hd0);
    rchk(`CEF_REG_STATUS, 32'h00000000);
    gnets <= 4'h1;
    repeat (6) @(posedge clk_sys);
    rchk(`CEF_REG_STATUS, 32'h00010000);
    gnets <= 4'h0;
    apb(1'b1, `CEF_REG_CTRL, 32'h00000005);
    pop(32'hd0, 1'b1);
  endtask
  task automatic t_show;
    lrst;
    apb(1'b1, `CEF_REG_CTRL, 32'h0000000d);
    push(8'd2, 32'hc0);
    chk({31'h0, pop_valid}, 32'h1);
    chk(pop_data, 32'hc0);
    pop_enable <= 1'b1;
    @(posedge clk_sys);
    pop_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(pop_data, 32'hc1);
    apb(1'b1, `CEF_REG_CTRL, 32'h00000005);
  endtask
  // Entries keep only the low bits of the chosen width
  task automatic t_width;
    logic [31:0] m;
    for (int c = 0; c < 6; c++) begin
      m = (c == 5) ? 32'hffffffff : (32'h1 << (1 << c)) - 32'h1;
      apb(1'b1, `CEF_REG_CTRL, c);
      lrst;
      push(8'd1, 32'h5ac3e7b9);
      pop(32'h5ac3e7b9 & m, 1'b1);
    end
  endtask
  task automatic t_reset;
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rchk(`CEF_REG_FULL_THR, 32'h00004000);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    {resetn, psel, penable, pwrite, local_reset, go} = 6'h0;
    {pop_enable, rewind_req, paddr, pwdata} = 46'h0;
    {n_words, base} = 40'h0;
    gnets = 4'h0;
    {num_errors, comparisons, cyc} = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs;
    t_fill;
    t_rewind;
    t_show;
    t_width;
    t_nets;
    t_reset;
    tally_and_finish;
  end
endmodule
